// ===== core/iwwu_irq_wakeup_watchdog.sv
// Operation
// - one level, one vector, nine sources, each with its own enable bit
// - every event sets its pending flag regardless of enable
// - enabled pending taken at instruction end: call 004, set in-service
// - in-service clears in instruction after return, one main instruction runs
// - request is a level held while any enabled flag is pending and in-service is clear
// - enable bits: 7 conv, 6 slow, 5 second, 4 first, 3 wakeup, 2..0 pins
// - hardware sets flags, writing zero clears, same positions as enables
// - conversion end sets flag bit 7
// - pin c falling edge sets flag bit 2
// - pins a and b set bits 0 and 1 on selected edge
// - touch flag set at conversion end, cleared by zero or start write
// - watchdog and wakeup share slow oscillator, separate counters, 2-bit selects
// - clear watchdog by instruction or any write to clear register
// - watchdog overflow resets chip when enabled in config
// - sleep-run bit zero stops watchdog in sleep, one keeps counting
// - wakeup timer is interval timer, timeout sets flag bit 3
// - wakeup enable zero clears and stops counter, one runs always
// - watchdog select 128, 256, 1024, 2048 ms
// - wakeup select 16, 32, 64, 128 ms
// - first timer overflow sets flag bit 4
`timescale 1ns/10ps
module iwwu_irq_wakeup_watchdog #(
   parameter int TICK_CYCLES = iwwu_pkg::TICK_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata_q,
   output logic pready_q,
   output logic pslverr_q,
   input wire logic instr_boundary,
   input wire logic return_from_irq,
   input wire logic sleep_exec,
   input wire logic clear_dog_instruction,
   input wire logic conv_done,
   input wire logic slow_timer_ovf,
   input wire logic second_timer_ovf,
   input wire logic first_timer_ovf,
   input wire logic touch_conv_end,
   input wire logic touch_done,
   input wire logic ext_pin_a,
   input wire logic ext_pin_b,
   input wire logic ext_pin_c,
   output logic irq_call_q,
   output logic [11:0] irq_vector_q,
   output logic in_service_q,
   output logic wake_q,
   output logic chip_reset_q,
   output logic touch_conv_start_q,
   output logic [3:0] touch_channel_select_q
);
   logic [7:0] irq_enable_q;
   logic [7:0] irq_pending_q;
   logic [7:0] irq_pending_d;
   logic [7:0] timer_period_option_q;
   logic [1:0] config_word_high_q;
   logic touch_done_flag_q;
   logic touch_irq_enable_q;
   logic ret_armed_q;
   logic asleep_q;
   logic [2:0] pin_s1_q;
   logic [2:0] pin_s2_q;
   logic [2:0] pin_s3_q;
   logic [31:0] tick_cnt_q;
   logic tick_q;
   logic dog_timeout;
   logic wkt_timeout;
   logic dog_run;
   logic dog_clr;
   logic [iwwu_pkg::CNT_W-1:0] dog_limit;
   logic [iwwu_pkg::CNT_W-1:0] wkt_limit;
   logic [7:0] hw_set;
   logic pin_a_edge;
   logic pin_b_edge;
   logic pin_c_fall;
   logic [iwwu_pkg::NUM_SOURCES-1:0] active;
   logic req;
   logic acc;
   logic wr;
   logic [9:0] idx;
   logic mapped;
   logic [7:0] rdata;

   // apb decode
   assign acc = psel && penable;
   assign wr = acc && pwrite && pready_q && mapped; // refused addresses write nothing
   assign idx = paddr[11:2];
   always_comb begin
      mapped = (paddr[1:0] == 2'h0);
      rdata = 8'h00;
      case (idx)
         iwwu_pkg::IDX_IRQ_ENABLE: rdata = irq_enable_q;
         iwwu_pkg::IDX_IRQ_PENDING: rdata = irq_pending_q;
         iwwu_pkg::IDX_TOUCH_CTRL: rdata = {touch_done_flag_q, touch_irq_enable_q, 1'b0,
                                            touch_conv_end, touch_channel_select_q};
         iwwu_pkg::IDX_PERIOD_OPT: rdata = timer_period_option_q;
         iwwu_pkg::IDX_DOG_CLEAR: rdata = 8'h00;
         iwwu_pkg::IDX_CONFIG_HIGH: rdata = {6'h00, config_word_high_q};
         default: mapped = 1'b0;
      endcase
   end

   // apb answer one cycle into the access phase
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else begin
         pready_q <= acc && !pready_q;
         pslverr_q <= acc && !pready_q && !mapped;
         if (acc && !pready_q) begin
            prdata_q <= {24'h00_0000, mapped ? rdata : 8'h00};
         end
      end
   end

   // enable, option and config registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq_enable_q <= iwwu_pkg::RST_IRQ_ENABLE;
         timer_period_option_q <= iwwu_pkg::RST_PERIOD_OPT;
         config_word_high_q <= iwwu_pkg::RST_CONFIG_HIGH;
      end else if (wr) begin
         if (idx == iwwu_pkg::IDX_IRQ_ENABLE) begin
            irq_enable_q <= pwdata[7:0];
         end
         if (idx == iwwu_pkg::IDX_PERIOD_OPT) begin
            timer_period_option_q <= pwdata[7:0];
         end
         if (idx == iwwu_pkg::IDX_CONFIG_HIGH) begin
            config_word_high_q <= pwdata[1:0];
         end
      end
   end

   // pin synchronisers and edge history
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pin_s1_q <= 3'h7;
         pin_s2_q <= 3'h7;
         pin_s3_q <= 3'h7;
      end else begin
         pin_s1_q <= {ext_pin_c, ext_pin_b, ext_pin_a};
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
      end
   end

   // edge select: 0 rising, 1 falling
   assign pin_a_edge = timer_period_option_q[iwwu_pkg::OPT_PIN_A_EDGE]
                       ? (pin_s3_q[0] && !pin_s2_q[0])
                       : (!pin_s3_q[0] && pin_s2_q[0]);
   assign pin_b_edge = timer_period_option_q[iwwu_pkg::OPT_PIN_B_EDGE]
                       ? (pin_s3_q[1] && !pin_s2_q[1])
                       : (!pin_s3_q[1] && pin_s2_q[1]);
   assign pin_c_fall = pin_s3_q[2] && !pin_s2_q[2];

   // hardware set vector
   assign hw_set = {conv_done, slow_timer_ovf, second_timer_ovf, first_timer_ovf,
                    wkt_timeout, pin_c_fall, pin_b_edge, pin_a_edge};

   // pending flags: write zero clears, set wins
   always_comb begin
      irq_pending_d = irq_pending_q;
      if (wr && idx == iwwu_pkg::IDX_IRQ_PENDING) begin
         irq_pending_d = irq_pending_q & pwdata[7:0];
      end
      irq_pending_d = irq_pending_d | hw_set;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq_pending_q <= iwwu_pkg::RST_IRQ_PENDING;
      end else begin
         irq_pending_q <= irq_pending_d;
      end
   end

   // touch control: flag, enable, start pulse, channel
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         touch_done_flag_q <= 1'b0;
         touch_irq_enable_q <= 1'b0;
         touch_conv_start_q <= 1'b0;
         touch_channel_select_q <= iwwu_pkg::RST_TOUCH_CHAN;
      end else begin
         touch_conv_start_q <= 1'b0;
         if (wr && idx == iwwu_pkg::IDX_TOUCH_CTRL) begin
            touch_irq_enable_q <= pwdata[iwwu_pkg::TK_IE];
            touch_conv_start_q <= pwdata[iwwu_pkg::TK_START];
            touch_channel_select_q <= pwdata[3:0];
            if (!pwdata[iwwu_pkg::TK_FLAG] || pwdata[iwwu_pkg::TK_START]) begin
               touch_done_flag_q <= 1'b0;
            end
         end
         if (touch_done) begin
            touch_done_flag_q <= 1'b1;
         end
      end
   end

   // level request over all nine sources
   assign active = {touch_done_flag_q && touch_irq_enable_q,
                    irq_pending_q & irq_enable_q};
   assign req = (|active) && !in_service_q;

   // acceptance, in-service and return handling
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq_call_q <= 1'b0;
         in_service_q <= 1'b0;
         ret_armed_q <= 1'b0;
         irq_vector_q <= iwwu_pkg::IRQ_VECTOR;
      end else begin
         irq_call_q <= req && instr_boundary;
         irq_vector_q <= iwwu_pkg::IRQ_VECTOR;
         if (req && instr_boundary) begin
            in_service_q <= 1'b1;
         end else if (instr_boundary && ret_armed_q) begin
            in_service_q <= 1'b0;
         end
         if (instr_boundary && ret_armed_q) begin
            ret_armed_q <= 1'b0;
         end else if (instr_boundary && return_from_irq && in_service_q) begin
            ret_armed_q <= 1'b1;
         end
      end
   end

   // sleep state and wake request
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         asleep_q <= 1'b0;
         wake_q <= 1'b0;
      end else begin
         wake_q <= |active;
         if (|active) begin
            asleep_q <= 1'b0;
         end else if (sleep_exec) begin
            asleep_q <= 1'b1;
         end
      end
   end

   // shared slow oscillator tick
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tick_cnt_q <= 32'h0000_0000;
         tick_q <= 1'b0;
      end else begin
         tick_q <= (tick_cnt_q == 32'(TICK_CYCLES - 1));
         tick_cnt_q <= (tick_cnt_q == 32'(TICK_CYCLES - 1)) ? 32'h0000_0000
                       : tick_cnt_q + 32'h0000_0001;
      end
   end

   // period selects
   always_comb begin
      case (timer_period_option_q[iwwu_pkg::OPT_DOG_LO +: 2])
         2'h0: dog_limit = iwwu_pkg::DOG_T0;
         2'h1: dog_limit = iwwu_pkg::DOG_T1;
         2'h2: dog_limit = iwwu_pkg::DOG_T2;
         default: dog_limit = iwwu_pkg::DOG_T3;
      endcase
      case (timer_period_option_q[iwwu_pkg::OPT_WKT_LO +: 2])
         2'h0: wkt_limit = iwwu_pkg::WKT_T0;
         2'h1: wkt_limit = iwwu_pkg::WKT_T1;
         2'h2: wkt_limit = iwwu_pkg::WKT_T2;
         default: wkt_limit = iwwu_pkg::WKT_T3;
      endcase
   end

   // watchdog run and clear conditions
   assign dog_run = config_word_high_q[iwwu_pkg::CFG_DOG_EN]
                    && (!asleep_q || config_word_high_q[iwwu_pkg::CFG_SLEEP_RUN]);
   assign dog_clr = clear_dog_instruction
                    || (wr && idx == iwwu_pkg::IDX_DOG_CLEAR);

   // separate counters on the shared tick
   iwwu_interval_timer u_dog (
      .clk(clk),
      .rst(rst),
      .tick(tick_q),
      .run(dog_run),
      .clr(dog_clr),
      .limit(dog_limit),
      .timeout_q(dog_timeout)
   );

   iwwu_interval_timer u_wkt (
      .clk(clk),
      .rst(rst),
      .tick(tick_q),
      .run(irq_enable_q[iwwu_pkg::B_WAKEUP]),
      .clr(!irq_enable_q[iwwu_pkg::B_WAKEUP]),
      .limit(wkt_limit),
      .timeout_q(wkt_timeout)
   );

   // chip reset on watchdog overflow
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         chip_reset_q <= 1'b0;
      end else begin
         chip_reset_q <= dog_timeout && config_word_high_q[iwwu_pkg::CFG_DOG_EN];
      end
   end

   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_take_cause: assert property (irq_call_q |-> $past(req) && $past(instr_boundary))
      else $error("call without enabled pending request at boundary");
   a_take_marks: assert property (irq_call_q |-> in_service_q)
      else $error("in-service not set on acceptance");
   a_no_nesting: assert property (irq_call_q |-> !$past(in_service_q))
      else $error("nested acceptance");
   a_ret_clears: assert property (instr_boundary && ret_armed_q && !req
                                  |=> !in_service_q && !irq_call_q)
      else $error("in-service not cleared after return");
   a_level_take: assert property (instr_boundary && (|active) && !in_service_q
                                  |=> irq_call_q)
      else $error("enabled pending not taken");
   a_flag_any_en: assert property (first_timer_ovf && !irq_enable_q[iwwu_pkg::B_FIRST]
                                   |=> irq_pending_q[iwwu_pkg::B_FIRST])
      else $error("event lost while disabled");
   a_set_wins: assert property (wr && idx == iwwu_pkg::IDX_IRQ_PENDING && conv_done
                                |=> irq_pending_q[iwwu_pkg::B_CONV])
      else $error("clear beat hardware set");
   a_pin_c_edge: assert property ($fell(pin_s2_q[2]) |=> irq_pending_q[iwwu_pkg::B_PIN_C])
      else $error("pin c fall not flagged");
   a_touch_start: assert property (wr && idx == iwwu_pkg::IDX_TOUCH_CTRL
                                   && pwdata[iwwu_pkg::TK_START] && !touch_done
                                   |=> !touch_done_flag_q && touch_conv_start_q)
      else $error("touch start did not clear flag");
   a_wkt_stopped: assert property (!irq_enable_q[iwwu_pkg::B_WAKEUP] |=> !wkt_timeout)
      else $error("wakeup timeout while disabled");
   a_dog_reset: assert property (dog_timeout && config_word_high_q[iwwu_pkg::CFG_DOG_EN]
                                 |=> chip_reset_q)
      else $error("watchdog overflow without reset");

   c_take: cover property (irq_call_q);
   c_return: cover property (ret_armed_q && instr_boundary ##1 !in_service_q);
   c_wkt_flag: cover property (wkt_timeout ##1 irq_pending_q[iwwu_pkg::B_WAKEUP]);
   c_dog_reset: cover property (chip_reset_q);
endmodule

// ===== core/iwwu_pkg.sv
package iwwu_pkg;
   // register indices; byte address is four times the index
   localparam logic [9:0] IDX_IRQ_ENABLE = 10'h00b;
   localparam logic [9:0] IDX_IRQ_PENDING = 10'h00c;
   localparam logic [9:0] IDX_TOUCH_CTRL = 10'h01f;
   localparam logic [9:0] IDX_PERIOD_OPT = 10'h081;
   localparam logic [9:0] IDX_DOG_CLEAR = 10'h020;
   localparam logic [9:0] IDX_CONFIG_HIGH = 10'h021;

   // reset values
   localparam logic [7:0] RST_IRQ_ENABLE = 8'h00;
   localparam logic [7:0] RST_IRQ_PENDING = 8'h00;
   localparam logic [3:0] RST_TOUCH_CHAN = 4'hf;
   localparam logic [7:0] RST_PERIOD_OPT = 8'h0f;
   localparam logic [1:0] RST_CONFIG_HIGH = 2'h0;

   // source bit positions, shared by enable and pending registers
   localparam int B_CONV = 7;
   localparam int B_SLOW = 6;
   localparam int B_SECOND = 5;
   localparam int B_FIRST = 4;
   localparam int B_WAKEUP = 3;
   localparam int B_PIN_C = 2;
   localparam int B_PIN_B = 1;
   localparam int B_PIN_A = 0;
   localparam int NUM_SOURCES = 9;

   // touch control fields
   localparam int TK_FLAG = 7;
   localparam int TK_IE = 6;
   localparam int TK_START = 5;
   localparam int TK_END = 4;

   // option fields
   localparam int OPT_PIN_A_EDGE = 6;
   localparam int OPT_PIN_B_EDGE = 5;
   localparam int OPT_DOG_LO = 2;
   localparam int OPT_WKT_LO = 0;

   // config word high fields
   localparam int CFG_DOG_EN = 1;
   localparam int CFG_SLEEP_RUN = 0;

   // call vector inserted on interrupt acceptance
   localparam logic [11:0] IRQ_VECTOR = 12'h004;

   // clock and slow oscillator tick
   localparam int CLK_MHZ = 250;
   localparam int TICK_MS = 1;
   localparam int TICK_CYCLES = TICK_MS * CLK_MHZ * 1000;

   // periods in ms and in slow ticks
   localparam int DOG_MS_0 = 128;
   localparam int DOG_MS_1 = 256;
   localparam int DOG_MS_2 = 1024;
   localparam int DOG_MS_3 = 2048;
   localparam int WKT_MS_0 = 16;
   localparam int WKT_MS_1 = 32;
   localparam int WKT_MS_2 = 64;
   localparam int WKT_MS_3 = 128;
   localparam int CNT_W = 12;
   localparam logic [CNT_W-1:0] DOG_T0 = CNT_W'(DOG_MS_0 / TICK_MS);
   localparam logic [CNT_W-1:0] DOG_T1 = CNT_W'(DOG_MS_1 / TICK_MS);
   localparam logic [CNT_W-1:0] DOG_T2 = CNT_W'(DOG_MS_2 / TICK_MS);
   localparam logic [CNT_W-1:0] DOG_T3 = CNT_W'(DOG_MS_3 / TICK_MS);
   localparam logic [CNT_W-1:0] WKT_T0 = CNT_W'(WKT_MS_0 / TICK_MS);
   localparam logic [CNT_W-1:0] WKT_T1 = CNT_W'(WKT_MS_1 / TICK_MS);
   localparam logic [CNT_W-1:0] WKT_T2 = CNT_W'(WKT_MS_2 / TICK_MS);
   localparam logic [CNT_W-1:0] WKT_T3 = CNT_W'(WKT_MS_3 / TICK_MS);
endpackage

// ===== core/iwwu_interval_timer.sv
`timescale 1ns/10ps
module iwwu_interval_timer (
   input wire logic clk,
   input wire logic rst,
   input wire logic tick,
   input wire logic run,
   input wire logic clr,
   input wire logic [iwwu_pkg::CNT_W-1:0] limit,
   output logic timeout_q
);
   logic [iwwu_pkg::CNT_W-1:0] count_q;
   logic at_end;

   assign at_end = (count_q >= limit - iwwu_pkg::CNT_W'(1));

   // counts slow ticks, wraps at the selected period
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         count_q <= '0;
      end else if (clr) begin
         count_q <= '0;
      end else if (run && tick) begin
         count_q <= at_end ? '0 : count_q + iwwu_pkg::CNT_W'(1);
      end
   end

   // one-cycle pulse on wrap
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         timeout_q <= 1'b0;
      end else begin
         timeout_q <= !clr && run && tick && at_end;
      end
   end
endmodule

// ===== tb/iwwu_core_model.sv
`timescale 1ns/10ps
module iwwu_core_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic [3:0] gap,
   input wire logic ret_req,
   input wire logic irq_call,
   output logic instr_boundary,
   output logic return_from_irq
);
   logic [3:0] cnt_q;
   logic ret_q;
   logic isr_q;

   // instruction length counter, gap zero ends an instruction every cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         cnt_q <= 4'h0;
      else if (cnt_q >= gap)
         cnt_q <= 4'h0;
      else
         cnt_q <= cnt_q + 4'h1;
   end

   assign instr_boundary = !rst && (cnt_q >= gap);

   // handler state, a return is only issued from inside a handler
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         isr_q <= 1'b0;
         ret_q <= 1'b0;
      end else begin
         if (irq_call)
            isr_q <= 1'b1;
         else if (instr_boundary && ret_q && isr_q)
            isr_q <= 1'b0;
         if (ret_req)
            ret_q <= 1'b1;
         else if (instr_boundary && isr_q)
            ret_q <= 1'b0;
      end
   end

   // return only means something at a boundary, toggles elsewhere
   assign return_from_irq = instr_boundary ? (ret_q && isr_q) : cnt_q[0];
endmodule

// ===== tb/test_irq_wakeup_watchdog_unit.sv
`timescale 1ns/10ps
module test_irq_wakeup_watchdog_unit;
   localparam int TICK = 4;
   localparam logic [11:0] A_EN = {iwwu_pkg::IDX_IRQ_ENABLE, 2'b00};
   localparam logic [11:0] A_PD = {iwwu_pkg::IDX_IRQ_PENDING, 2'b00};
   localparam logic [11:0] A_TK = {iwwu_pkg::IDX_TOUCH_CTRL, 2'b00};
   localparam logic [11:0] A_OP = {iwwu_pkg::IDX_PERIOD_OPT, 2'b00};
   localparam logic [11:0] A_DC = {iwwu_pkg::IDX_DOG_CLEAR, 2'b00};
   localparam logic [11:0] A_CF = {iwwu_pkg::IDX_CONFIG_HIGH, 2'b00};
   logic clk, rst, psel, penable, pwrite, pready_q, pslverr_q, ret_req;
   logic [11:0] paddr, irq_vector_q;
   logic [31:0] pwdata, prdata_q;
   logic instr_boundary, return_from_irq, sleep_exec, clr_ins, touch_done, touch_conv_end;
   logic ext_pin_a, ext_pin_b, ext_pin_c, irq_call_q, in_service_q, wake_q, chip_reset_q;
   logic touch_conv_start_q;
   logic [3:0] ev, gap, touch_channel_select_q;
   int num_errors, compares, calls, resets, idle_b, idle_at_call, starts;

   iwwu_irq_wakeup_watchdog #(.TICK_CYCLES(TICK)) dut (.clk(clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q),
      .instr_boundary(instr_boundary), .return_from_irq(return_from_irq),
      .sleep_exec(sleep_exec), .clear_dog_instruction(clr_ins), .conv_done(ev[3]),
      .slow_timer_ovf(ev[2]), .second_timer_ovf(ev[1]), .first_timer_ovf(ev[0]),
      .touch_conv_end(touch_conv_end), .touch_done(touch_done), .ext_pin_a(ext_pin_a),
      .ext_pin_b(ext_pin_b), .ext_pin_c(ext_pin_c), .irq_call_q(irq_call_q),
      .irq_vector_q(irq_vector_q), .in_service_q(in_service_q), .wake_q(wake_q),
      .chip_reset_q(chip_reset_q), .touch_conv_start_q(touch_conv_start_q),
      .touch_channel_select_q(touch_channel_select_q));

   iwwu_core_model core (.clk(clk), .rst(rst), .gap(gap), .ret_req(ret_req),
      .irq_call(irq_call_q), .instr_boundary(instr_boundary),
      .return_from_irq(return_from_irq));

   // clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // event counters, boundaries seen while out of service
   always @(posedge clk) begin
      if (irq_call_q === 1'b1) begin
         calls <= calls + 1;
         idle_at_call <= idle_b;
      end
      if (in_service_q === 1'b1)
         idle_b <= 0;
      else if (instr_boundary === 1'b1)
         idle_b <= idle_b + 1;
      if (chip_reset_q === 1'b1)
         resets <= resets + 1;
      if (touch_conv_start_q === 1'b1)
         starts <= starts + 1;
   end

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
         output logic [31:0] rd, output logic err);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready_q !== 1'b1 && n < 20);
      if (n >= 20) begin
         num_errors++;
         $display("BAD pready exp 1 seen 0");
      end
      rd = prdata_q;
      err = pslverr_q;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, {24'h0, d}, r, e);
   endtask

   task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] exp,
         input logic xe);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      chk(nm, r, exp);
      chk({nm, "_err"}, {31'h0, e}, {31'h0, xe});
   endtask

   // waits for wake, chip reset, call or end of service
   task automatic wait_on(input int which, input int lim, output int n);
      n = 0;
      while (n < lim && (which == 0 ? wake_q : which == 1 ? chip_reset_q :
            which == 2 ? irq_call_q : !in_service_q) !== 1'b1) begin
         @(posedge clk);
         n++;
      end
   endtask

   task automatic pulse_ev(input logic [3:0] v);
      @(posedge clk);
      ev <= v;
      @(posedge clk);
      ev <= 4'h0;
   endtask

   task automatic ret;
      @(posedge clk);
      ret_req <= 1'b1;
      @(posedge clk);
      ret_req <= 1'b0;
   endtask

   task automatic do_reset;
      rst <= 1'b1;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
   endtask

   task automatic t_reset;
      chk("vec", {20'h0, irq_vector_q}, {20'h0, iwwu_pkg::IRQ_VECTOR});
      chk("chan", {28'h0, touch_channel_select_q}, 32'hf);
      rdc("en", A_EN, 32'h0, 1'b0);
      rdc("pd", A_PD, 32'h0, 1'b0);
      rdc("tk", A_TK, 32'h1f, 1'b0);
      rdc("op", A_OP, 32'h0f, 1'b0);
      wr(A_EN + 12'h1, 8'hff);
      rdc("bad", 12'h100, 32'h0, 1'b1);
      rdc("en2", A_EN, 32'h0, 1'b0);
      $display("reset values end");
   endtask

   // masked events still pend, enable maps to request, writing zero clears
   task automatic t_sources;
      for (int i = 0; i < 4; i++) begin
         wr(A_EN, ~(8'h10 << i));
         pulse_ev(4'h1 << i);
         repeat (2) @(posedge clk);
         chk("mask", {31'h0, wake_q}, 32'h0);
         rdc("flag", A_PD, 32'h10 << i, 1'b0);
         wr(A_EN, 8'h10 << i);
         repeat (2) @(posedge clk);
         chk("req", {31'h0, wake_q}, 32'h1);
         wr(A_PD, ~(8'h10 << i));
         rdc("clr", A_PD, 32'h0, 1'b0);
      end
      wr(A_EN, 8'h00);
      pulse_ev(4'h1);
      fork
         wr(A_PD, 8'h10);
         begin
            repeat (3) @(posedge clk);
            ev <= 4'h8;
            @(posedge clk);
            ev <= 4'h0;
         end
      join
      rdc("race", A_PD, 32'h90, 1'b0);
      $display("sources end");
   endtask

   task automatic t_irq(input logic [3:0] g);
      int n;
      int c0;
      gap <= g;
      do_reset;
      wr(A_EN, 8'h10);
      pulse_ev(4'h1);
      wait_on(2, 60, n);
      chk("call", {31'h0, n < 60}, 32'h1);
      @(posedge clk);
      chk("isr", {31'h0, in_service_q}, 32'h1);
      chk("vec", {20'h0, irq_vector_q}, 32'h4);
      c0 = calls;
      repeat (40) @(posedge clk);
      chk("nest", calls, c0);
      ret;
      wait_on(3, 60, n);
      wait_on(2, 60, n);
      chk("retake", {31'h0, n < 60}, 32'h1);
      @(posedge clk);
      chk("one_instr", idle_at_call, 32'h1);
      wr(A_PD, 8'hef);
      c0 = calls;
      ret;
      wait_on(3, 60, n);
      repeat (40) @(posedge clk);
      chk("served", calls, c0);
      chk("wake", {31'h0, wake_q}, 32'h0);
      $display("irq gap %0d end", g);
   endtask

   // pin a rising, pin b falling, pin c always falling
   task automatic t_pins;
      logic [2:0] lv[5] = '{3'b101, 3'b111, 3'b101, 3'b001, 3'b000};
      logic [7:0] ex[5] = '{8'h01, 8'h01, 8'h03, 8'h07, 8'h07};
      wr(A_PD, 8'h00);
      wr(A_OP, 8'h2f);
      for (int i = 0; i < 5; i++) begin
         @(posedge clk);
         {ext_pin_c, ext_pin_b, ext_pin_a} <= lv[i];
         repeat (6) @(posedge clk);
         rdc("pin", A_PD, {24'h0, ex[i]}, 1'b0);
      end
      $display("pins end");
   endtask

   task automatic t_touch;
      int s0;
      touch_conv_end <= 1'b0;
      wr(A_TK, 8'h40);
      @(posedge clk);
      touch_done <= 1'b1;
      @(posedge clk);
      touch_done <= 1'b0;
      rdc("tkf", A_TK, 32'hc0, 1'b0);
      chk("tkreq", {31'h0, wake_q}, 32'h1);
      s0 = starts;
      wr(A_TK, 8'he3);
      rdc("tks", A_TK, 32'h43, 1'b0);
      chk("start", starts - s0, 32'h1);
      chk("chan", {28'h0, touch_channel_select_q}, 32'h3);
      @(posedge clk);
      touch_done <= 1'b1;
      @(posedge clk);
      touch_done <= 1'b0;
      wr(A_TK, 8'h40);
      rdc("tkz", A_TK, 32'h40, 1'b0);
      $display("touch end");
   endtask

   task automatic t_wakeup;
      int wp[4] = '{16, 32, 64, 128};
      int n;
      int p;
      for (int s = 0; s < 4; s++) begin
         wr(A_OP, 8'h0c | 8'(s));
         wr(A_EN, 8'h00);
         wr(A_PD, 8'hf7);
         wr(A_EN, 8'h08);
         p = wp[s] * TICK;
         wait_on(0, p + 8 * TICK, n);
         chk("wkt", {31'h0, n >= p - 3 * TICK && n <= p + 2 * TICK}, 32'h1);
      end
      wr(A_OP, 8'h0c);
      wr(A_EN, 8'h00);
      wr(A_PD, 8'h00);
      repeat (40 * TICK) @(posedge clk);
      rdc("wkstop", A_PD, 32'h0, 1'b0);
      $display("wakeup end");
   endtask

   task automatic t_dog;
      int dp[4] = '{128, 256, 1024, 2048};
      int n;
      int p;
      int r0;
      wr(A_CF, 8'h02);
      for (int s = 0; s < 4; s++) begin
         wr(A_OP, {4'h0, 2'(s), 2'b11});
         wr(A_DC, 8'h5a);
         p = dp[s] * TICK;
         wait_on(1, p + 8 * TICK, n);
         chk("dog", {31'h0, n >= p - 3 * TICK && n <= p + 2 * TICK}, 32'h1);
      end
      wr(A_OP, 8'h03);
      wr(A_DC, 8'h00);
      r0 = resets;
      repeat (100 * TICK) @(posedge clk);
      @(posedge clk);
      clr_ins <= 1'b1;
      @(posedge clk);
      clr_ins <= 1'b0;
      repeat (100 * TICK) @(posedge clk);
      chk("clrins", resets, r0);
      wait_on(1, 40 * TICK, n);
      chk("fire", {31'h0, n < 40 * TICK}, 32'h1);
      wr(A_DC, 8'h00);
      @(posedge clk);
      sleep_exec <= 1'b1;
      @(posedge clk);
      sleep_exec <= 1'b0;
      r0 = resets;
      repeat (200 * TICK) @(posedge clk);
      chk("sleep", resets, r0);
      wr(A_CF, 8'h03);
      wait_on(1, 140 * TICK, n);
      chk("sleeprun", {31'h0, n < 140 * TICK}, 32'h1);
      wr(A_CF, 8'h00);
      r0 = resets;
      repeat (140 * TICK) @(posedge clk);
      chk("dogoff", resets, r0);
      $display("watchdog end");
   endtask

   task automatic summarize;
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // hang guard
   initial begin
      #160000;
      num_errors++;
      $display("BAD watchdog exp done seen hang");
      summarize;
   end

   // main sequence
   initial begin
      {psel, penable, pwrite, ret_req, sleep_exec, clr_ins, touch_done} = 7'h0;
      {ext_pin_c, ext_pin_b, ext_pin_a} = 3'b100;
      touch_conv_end = 1'b1;
      paddr = 12'h0;
      pwdata = 32'h0;
      ev = 4'h0;
      gap = 4'h2;
      do_reset;
      t_reset;
      t_sources;
      t_irq(4'h0);
      t_irq(4'h5);
      t_pins;
      t_touch;
      t_wakeup;
      t_dog;
      summarize;
   end
endmodule
